// [rtl/cfp_pkg.sv]
// shared constants and types for the core fetch pipeline block
package cfp_pkg;
    localparam int PC_W            = 13;
    localparam int IW              = 14;
    localparam int DW              = 8;
    localparam int PROG_WORDS_DEF  = 1024;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
    // file locations inside a bank (seven-bit offsets)
    localparam logic [6:0] IDX_INDIRECT  = 7'h00;
    localparam logic [6:0] IDX_PC_LOW    = 7'h02;
    localparam logic [6:0] IDX_FLAGS     = 7'h03;
    localparam logic [6:0] IDX_POINTER   = 7'h04;
    localparam logic [6:0] IDX_PC_HIGH   = 7'h0A;
    localparam logic [6:0] IDX_INT_CTRL  = 7'h0B;
    localparam logic [6:0] GPR_LO        = 7'h20;
    localparam logic [6:0] COMMON_LO     = 7'h70;
    localparam logic [7:0] GPR_BANK1_OFS = 8'h40;
    localparam int GPR_WORDS  = 176;
    localparam int PERI_WORDS = 64;
    // peripheral locations, full eight-bit file addresses
    localparam logic [7:0] ADR_TIMER     = 8'h01;
    localparam logic [7:0] ADR_IO_PINS   = 8'h05;
    localparam logic [7:0] ADR_EVT_FLAGS = 8'h0C;
    localparam logic [7:0] ADR_CONV_RES  = 8'h1E;
    localparam logic [7:0] ADR_CONV_CTL0 = 8'h1F;
    localparam logic [7:0] ADR_OPTIONS   = 8'h81;
    localparam logic [7:0] ADR_PIN_DIR   = 8'h85;
    localparam logic [7:0] ADR_EVT_EN    = 8'h8C;
    localparam logic [7:0] ADR_RST_CAUSE = 8'h8E;
    localparam logic [7:0] ADR_OSC_TRIM  = 8'h8F;
    localparam logic [7:0] ADR_CONV_CTL1 = 8'h9F;
    // field positions and reset values
    localparam int BANK_SEL_BIT = 5;
    localparam int GIE_BIT      = 7;
    localparam int INTE_BIT     = 4;
    localparam int INTF_BIT     = 1;
    localparam logic [7:0] FLAGS_RESET = 8'h18;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    // instruction encodings
    localparam logic [13:0] INSN_NOP   = 14'h0000;
    localparam logic [6:0]  OPC_STORE  = 7'h01;
    localparam logic [6:0]  OPC_LOAD   = 7'h10;
    localparam logic [5:0]  OPC_LIT    = 6'h30;
    localparam logic [2:0]  OPC_JUMP   = 3'h5;
    // bus map: word index, byte address is four times it
    localparam logic [9:0] BUS_FILE_TOP = 10'h0FF;
    localparam logic [9:0] BUS_DBG_PC   = 10'h100;
    localparam logic [9:0] BUS_DBG_WORK = 10'h101;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;

    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } cfp_phase_t;

    typedef enum logic [3:0] {
        K_NONE, K_IND, K_PCL, K_FLAGS, K_PTR, K_PCH, K_INTC, K_PERI, K_GPR
    } cfp_kind_t;

    typedef struct packed {
        cfp_kind_t  kind;
        logic [7:0] idx;
    } cfp_slot_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } cfp_fwrite_t;
endpackage

// [rtl/cfp_core_fetch.sv]
// fetch/execute pipeline, program counter and banked data file
////////////////////////////////////////////////////////////////////////////
// What this block does
// - divide the clock by four into four non-overlapping phases
// - each instruction cycle is phases one to four, in order
// - fetch of next word overlaps execution of current word
// - an instruction that changes the program counter takes two cycles
// - program counter increments in phase one of every fetch cycle
// - instruction register loads in phase one, executes in two to four
// - operand read in phase two, destination written in phase four
// - program counter is 13 bits over 14-bit words
// - implemented program memory is the lowest 1K or 2K words
// - addresses above implemented memory wrap into it
// - fetch starts at zero after reset, interrupt vectors to four
// - bit 5 of the core flags selects bank one for direct access
// - each bank holds 128 locations from a seven-bit offset
// - low locations are special registers, upper ones are RAM
// - the core registers answer the same in both banks
// - bank one F0h to FFh is the same RAM as bank zero 70h to 7Fh
// - file reachable directly and through the indirect pointer
//
// Decided for this implementation: register access over AXI4-Lite.
module cfp_core_fetch #(
    parameter int PROG_WORDS = cfp_pkg::PROG_WORDS_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    output logic      [12:0] progAddr,
    input  wire logic [13:0] progData,
    input  wire logic        irqPin,
    output logic      [3:0]  phase,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam logic [12:0] PROG_MASK = 13'(PROG_WORDS - 1);

    // classify a full file address into storage kind and index
    function automatic cfp_pkg::cfp_slot_t classify(input logic [7:0] a);
        cfp_pkg::cfp_slot_t s;
        logic [6:0]         o;
        o      = a[6:0];
        s.kind = cfp_pkg::K_NONE;
        s.idx  = cfp_pkg::ZERO_BYTE;
        if (o >= cfp_pkg::GPR_LO) begin
            s.kind = cfp_pkg::K_GPR;
            if (!a[7] || o >= cfp_pkg::COMMON_LO) begin
                s.idx = {1'b0, o - cfp_pkg::GPR_LO};
            end else begin
                s.idx = {1'b0, o} + cfp_pkg::GPR_BANK1_OFS;
            end
        end else begin
            case (o)
                cfp_pkg::IDX_INDIRECT: s.kind = cfp_pkg::K_IND;
                cfp_pkg::IDX_PC_LOW:   s.kind = cfp_pkg::K_PCL;
                cfp_pkg::IDX_FLAGS:    s.kind = cfp_pkg::K_FLAGS;
                cfp_pkg::IDX_POINTER:  s.kind = cfp_pkg::K_PTR;
                cfp_pkg::IDX_PC_HIGH:  s.kind = cfp_pkg::K_PCH;
                cfp_pkg::IDX_INT_CTRL: s.kind = cfp_pkg::K_INTC;
                default: begin
                    case (a)
                        cfp_pkg::ADR_TIMER, cfp_pkg::ADR_IO_PINS,
                        cfp_pkg::ADR_EVT_FLAGS, cfp_pkg::ADR_CONV_RES,
                        cfp_pkg::ADR_CONV_CTL0, cfp_pkg::ADR_OPTIONS,
                        cfp_pkg::ADR_PIN_DIR, cfp_pkg::ADR_EVT_EN,
                        cfp_pkg::ADR_RST_CAUSE, cfp_pkg::ADR_OSC_TRIM,
                        cfp_pkg::ADR_CONV_CTL1: begin
                            s.kind = cfp_pkg::K_PERI;
                            s.idx  = {2'b00, a[7], a[4:0]};
                        end
                        default: s.kind = cfp_pkg::K_NONE;
                    endcase
                end
            endcase
        end
        return s;
    endfunction

    // follow the indirect port through the pointer; a pointer that
    // names the port itself reads zero, so no loop can form
    function automatic cfp_pkg::cfp_slot_t resolve(input logic [7:0] a,
                                                   input logic [7:0] p);
        cfp_pkg::cfp_slot_t s;
        s = classify(a);
        if (s.kind == cfp_pkg::K_IND) begin
            s = classify(p);
            if (s.kind == cfp_pkg::K_IND) begin
                s.kind = cfp_pkg::K_NONE;
            end
        end
        return s;
    endfunction

    cfp_pkg::cfp_phase_t phaseState;
    cfp_pkg::cfp_phase_t next_phase;
    logic [12:0]         pc;
    logic [13:0]         ir;
    logic [13:0]         fetchWord;
    logic                flush;
    logic [7:0]          flags;
    logic [7:0]          pointer;
    logic [7:0]          pcHigh;
    logic [7:0]          intCtrl;
    logic [7:0]          work;
    logic [7:0]          operand;
    logic [7:0]          gpr  [cfp_pkg::GPR_WORDS];
    logic [7:0]          peri [cfp_pkg::PERI_WORDS];
    logic [2:0]          irqSync;
    logic                awHeld;
    logic                wHeld;
    logic                arHeld;
    logic [9:0]          awIdx;
    logic [9:0]          arIdx;
    logic [7:0]          wByte;
    logic                wLane;

    ////////////////////////////////////////////////////////////////////////
    // phase generator: a ring of four one-hot states
    always_comb begin
        case (phaseState)
            cfp_pkg::PH_ONE:   next_phase = cfp_pkg::PH_TWO;
            cfp_pkg::PH_TWO:   next_phase = cfp_pkg::PH_THREE;
            cfp_pkg::PH_THREE: next_phase = cfp_pkg::PH_FOUR;
            cfp_pkg::PH_FOUR:  next_phase = cfp_pkg::PH_ONE;
            default:           next_phase = cfp_pkg::PH_ONE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) phaseState <= cfp_pkg::PH_ONE;
        else        phaseState <= next_phase;
    end

    wire isOne   = (phaseState == cfp_pkg::PH_ONE);
    wire isTwo   = (phaseState == cfp_pkg::PH_TWO);
    wire isThree = (phaseState == cfp_pkg::PH_THREE);
    wire isFour  = (phaseState == cfp_pkg::PH_FOUR);
    assign phase = phaseState;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode
    wire isStore = (ir[13:7] == cfp_pkg::OPC_STORE);
    wire isLoad  = (ir[13:7] == cfp_pkg::OPC_LOAD);
    wire isLit   = (ir[13:8] == cfp_pkg::OPC_LIT);
    wire isJump  = (ir[13:11] == cfp_pkg::OPC_JUMP);
    wire [12:0] jumpTarget = {pcHigh[4:3], ir[10:0]};
    wire [7:0]  coreAddr   = {flags[cfp_pkg::BANK_SEL_BIT], ir[6:0]};

    ////////////////////////////////////////////////////////////////////////
    // bus side decode; the file is only lent to the bus in phase three,
    // when the core neither reads nor writes it
    wire busWrGo   = awHeld && wHeld && isThree && !s_axi_bvalid;
    wire busRdGo   = arHeld && isThree && !s_axi_rvalid;
    wire awFile    = (awIdx <= cfp_pkg::BUS_FILE_TOP);
    wire arFile    = (arIdx <= cfp_pkg::BUS_FILE_TOP);
    wire arDbgPc   = (arIdx == cfp_pkg::BUS_DBG_PC);
    wire arDbgWork = (arIdx == cfp_pkg::BUS_DBG_WORK);
    wire awKnown   = awFile || awIdx == cfp_pkg::BUS_DBG_PC
                     || awIdx == cfp_pkg::BUS_DBG_WORK;

    // one read port and one write port serve both core and bus
    wire [7:0] rdAddr = isThree ? arIdx[7:0] : coreAddr;
    wire cfp_pkg::cfp_slot_t rdSlot = resolve(rdAddr, pointer);
    cfp_pkg::cfp_fwrite_t fw;
    assign fw.en   = (isFour && isStore) || (busWrGo && awFile && wLane);
    assign fw.addr = isThree ? awIdx[7:0] : coreAddr;
    assign fw.data = isThree ? wByte : work;
    wire cfp_pkg::cfp_slot_t wrSlot = resolve(fw.addr, pointer);

    // read mux; unimplemented locations read zero
    wire [7:0] rdData =
        (rdSlot.kind == cfp_pkg::K_GPR)   ? gpr[rdSlot.idx] :
        (rdSlot.kind == cfp_pkg::K_PERI)  ? peri[rdSlot.idx[5:0]] :
        (rdSlot.kind == cfp_pkg::K_PCL)   ? pc[7:0] :
        (rdSlot.kind == cfp_pkg::K_FLAGS) ? flags :
        (rdSlot.kind == cfp_pkg::K_PTR)   ? pointer :
        (rdSlot.kind == cfp_pkg::K_PCH)   ? pcHigh :
        (rdSlot.kind == cfp_pkg::K_INTC)  ? intCtrl :
                                            cfp_pkg::ZERO_BYTE;

    wire pcWrite = fw.en && wrSlot.kind == cfp_pkg::K_PCL;
    wire irqEdge = irqSync[1] && !irqSync[2];
    wire takeIrq = isFour && !isJump && !pcWrite
                   && intCtrl[cfp_pkg::GIE_BIT]
                   && intCtrl[cfp_pkg::INTE_BIT]
                   && intCtrl[cfp_pkg::INTF_BIT];

    ////////////////////////////////////////////////////////////////////////
    // program counter, fetch address and instruction register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc       <= cfp_pkg::RESET_VECTOR;
            progAddr <= cfp_pkg::RESET_VECTOR;
            ir       <= cfp_pkg::INSN_NOP;
            flush    <= 1'b1;
        end else if (isOne) begin
            progAddr <= pc & PROG_MASK;
            pc       <= pc + 13'h0001;
            ir       <= flush ? cfp_pkg::INSN_NOP : fetchWord;
            flush    <= 1'b0;
        end else if (takeIrq) begin
            pc    <= cfp_pkg::IRQ_VECTOR;
            flush <= 1'b1;
        end else if (isFour && isJump) begin
            pc    <= jumpTarget;
            flush <= 1'b1;
        end else if (pcWrite) begin
            pc    <= {pcHigh[4:0], fw.data};
            flush <= 1'b1;
        end
    end

    // the word fetched this cycle is latched for the next one
    always_ff @(posedge clk_sys) begin
        if (!rst_n)      fetchWord <= cfp_pkg::INSN_NOP;
        else if (isFour) fetchWord <= progData;
    end

    ////////////////////////////////////////////////////////////////////////
    // operand read and working register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            operand <= cfp_pkg::ZERO_BYTE;
            work    <= cfp_pkg::ZERO_BYTE;
        end else if (isTwo) begin
            operand <= rdData;
        end else if (isFour && isLoad) begin
            work <= operand;
        end else if (isFour && isLit) begin
            work <= ir[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core registers; a bus or core write lands here in its phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags   <= cfp_pkg::FLAGS_RESET;
            pointer <= cfp_pkg::ZERO_BYTE;
            pcHigh  <= cfp_pkg::ZERO_BYTE;
        end else if (fw.en) begin
            case (wrSlot.kind)
                cfp_pkg::K_FLAGS: flags   <= fw.data;
                cfp_pkg::K_PTR:   pointer <= fw.data;
                cfp_pkg::K_PCH:   pcHigh  <= {3'b000, fw.data[4:0]};
                default:          pointer <= pointer;
            endcase
        end
    end

    // interrupt control: a pin edge wins over a clearing write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intCtrl <= cfp_pkg::ZERO_BYTE;
        end else begin
            if (fw.en && wrSlot.kind == cfp_pkg::K_INTC) intCtrl <= fw.data;
            if (takeIrq) intCtrl[cfp_pkg::GIE_BIT] <= 1'b0;
            if (irqEdge) intCtrl[cfp_pkg::INTF_BIT] <= 1'b1;
        end
    end

    // two-flop synchroniser plus one stage for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) irqSync <= 3'b000;
        else        irqSync <= {irqSync[1:0], irqPin};
    end

    // general purpose RAM and peripheral holding bytes; no reset,
    // their contents are undefined after power-up
    always_ff @(posedge clk_sys) begin
        if (fw.en && wrSlot.kind == cfp_pkg::K_GPR) begin
            gpr[wrSlot.idx] <= fw.data;
        end
        if (fw.en && wrSlot.kind == cfp_pkg::K_PERI) begin
            peri[wrSlot.idx[5:0]] <= fw.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write address and data channels are held independently
    assign s_axi_awready = !awHeld;
    assign s_axi_wready  = !wHeld;
    assign s_axi_arready = !arHeld;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awIdx  <= 10'h000;
            wByte  <= cfp_pkg::ZERO_BYTE;
            wLane  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awIdx  <= s_axi_awaddr[11:2];
            end else if (busWrGo) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
            end else if (busWrGo) begin
                wHeld <= 1'b0;
            end
        end
    end

    // write response; debug words are read-only and ignore writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cfp_pkg::RESP_OKAY;
        end else if (busWrGo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= awKnown ? cfp_pkg::RESP_OKAY
                                    : cfp_pkg::RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read address capture
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            arHeld <= 1'b0;
            arIdx  <= 10'h000;
        end else if (s_axi_arvalid && !arHeld) begin
            arHeld <= 1'b1;
            arIdx  <= s_axi_araddr[11:2];
        end else if (busRdGo) begin
            arHeld <= 1'b0;
        end
    end

    wire [31:0] rdWord =
        arFile    ? {24'h000000, rdData} :
        arDbgPc   ? {2'b00, ir, 3'b000, pc} :
        arDbgWork ? {24'h000000, work} : 32'h00000000;

    // read data, sampled in phase three
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= cfp_pkg::RESP_OKAY;
        end else if (busRdGo) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdWord;
            s_axi_rresp  <= (arFile || arDbgPc || arDbgWork)
                            ? cfp_pkg::RESP_OKAY : cfp_pkg::RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [testbench/cfp_core_fetch_monitor.sv]
// checker for the fetch pipeline block, bound to its ports
module cfp_core_fetch_monitor #(
    parameter int PROG_WORDS = cfp_pkg::PROG_WORDS_DEF
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [12:0] progAddr,
    input wire logic [3:0]  phase,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // a read beyond the map is taken, then answered with an error
    sequence sq_ar_high;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > 10'h101;
    endsequence
    sequence sq_rd_err;
        ##[1:8] (s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 0);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_phase_onehot: assert property ($onehot(phase))
        else $error("phase not one-hot");
    chk_phase_ring: assert property (phase == 4'h1 |=> phase == 4'h2 ##1
        phase == 4'h4 ##1 phase == 4'h8 ##1 phase == 4'h1)
        else $error("phase order broken");
    chk_addr_step: assert property (phase != 4'h1 |=> $stable(progAddr))
        else $error("fetch address moved outside phase one");
    chk_addr_wrap: assert property (progAddr < PROG_WORDS)
        else $error("fetch address beyond program memory");
    chk_write_phase: assert property ($rose(s_axi_bvalid) |->
        $past(phase) == 4'h4) else $error("write done off phase");
    chk_read_phase: assert property ($rose(s_axi_rvalid) |->
        $past(phase) == 4'h4) else $error("read done off phase");
    chk_write_done: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:5] s_axi_bvalid)
        else $error("write answer late");
    chk_read_busy: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_arready) else $error("read accepted while busy");
    chk_read_miss: assert property (sq_ar_high |-> sq_rd_err)
        else $error("unmapped read not refused");
endmodule

bind cfp_core_fetch cfp_core_fetch_monitor #(.PROG_WORDS(PROG_WORDS)) mon_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .progAddr(progAddr), .phase(phase),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid));

// [testbench/cfp_prog_mem.sv]
// program memory model: registered read, one word per clock
module cfp_prog_mem #(
    parameter int WORDS = 1024
) (
    input  wire logic        clk_sys,
    input  wire logic [12:0] addr,
    output logic      [13:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem [WORDS];
    // unloaded words are no-ops so a stray fetch stays harmless
    initial begin
        foreach (mem[i]) mem[i] = 14'h0000;
    end
    // only the low words exist; high address bits fold back in
    always_ff @(posedge clk_sys) begin
        data <= mem[addr % WORDS];
    end
endmodule

// [testbench/core_fetch_pipeline_and_memory_map_test.sv]
// self-checking bench for the fetch pipeline and file map
module core_fetch_pipeline_and_memory_map_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 1024;
    logic        clk_sys, rst_n, irqPin;
    logic [12:0] progAddr;
    logic [13:0] progData, w;
    logic [3:0]  phase;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          n_errors, total_checks, cur, ex, n, v;
    int          fm [256];
    int          wa [7] = '{'h21, 'hA1, 'h75, 'h8A, 'h84, 'hB0, 'h00};
    int          ra [8] = '{'h21, 'hA1, 'hF5, 'h0A, 'h04, 'h80, 'h30, 'hB0};

    cfp_core_fetch #(.PROG_WORDS(PW)) cfp_core_fetch_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .progAddr(progAddr),
        .progData(progData), .irqPin(irqPin), .phase(phase),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    cfp_prog_mem #(.WORDS(PW)) cfp_prog_mem_inst (
        .clk_sys(clk_sys), .addr(progAddr), .data(progData));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // address and data go out together; each drops once taken
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] dv);
        logic got;
        got = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!got) begin
            @(posedge clk_sys);
            // drop only once, so a following call may raise it cleanly
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
            r = s_axi_bresp;
        end
    endtask
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] dv,
                          output logic [1:0] rv);
        logic got;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!got) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            dv = s_axi_rdata;
            rv = s_axi_rresp;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reference file map: mirrors, common RAM, indirect pointer
    function automatic int canon(int a);
        if ((a & 'h7F) inside {2, 3, 4, 'hA, 'hB}) return a & 'h7F;
        if (a >= 'hF0) return a - 'h80;
        if ((a & 'h7F) == 0)
            return (fm[4] & 'h7F) == 0 ? -1 : canon(fm[4]);
        return a;
    endfunction
    task automatic mdl_wr(int a, int dv);
        int c;
        c = canon(a);
        if (c >= 0) fm[c] = (c == 'hA) ? dv & 'h1F : dv & 'hFF;
        bus_wr(12'(a * 4), 32'(dv));
    endtask
    task automatic rd_chk(int a);
        int c;
        c = canon(a);
        bus_rd(12'(a * 4), d, r);
        chk($sformatf("file %h", a), c < 0 ? 0 : fm[c], d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end
    // main sequence
    initial begin
        {rst_n, irqPin, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        fm = '{default: 0};
        fm['h30] = 'h55;
        void'($urandom(99528));
        repeat (4) @(posedge clk_sys);
        // loaded after the model clears its array at time zero
        cfp_prog_mem_inst.mem[0] = 14'h3055;
        cfp_prog_mem_inst.mem[1] = {cfp_pkg::OPC_STORE, 7'h30};
        cfp_prog_mem_inst.mem[2] = {cfp_pkg::OPC_JUMP, 11'h7FE};
        rst_n <= 1'b1;
        // fetch order: one word per cycle, jumps flush the prefetch
        cur = 0;
        ex = -1;
        repeat (40) begin
            do @(posedge clk_sys); while (phase !== 4'h2);
            chk("progAddr", 32'(cur), 32'(progAddr));
            w = ex < 0 ? cfp_pkg::INSN_NOP : cfp_prog_mem_inst.mem[ex];
            ex = w[13:11] == cfp_pkg::OPC_JUMP ? -1 : cur;
            cur = ex < 0 ? w[10:0] % PW : (cur + 1) % PW;
        end
        $display("test fetch order done");
        // random bytes through mirrors, common RAM and the pointer
        foreach (wa[i]) begin
            v = (wa[i] == 'h84) ? 'h40 + $urandom % 'h30 : $urandom;
            mdl_wr(wa[i], v);
        end
        foreach (ra[i]) rd_chk(ra[i]);
        bus_rd(12'h408, d, r);
        chk("miss resp", cfp_pkg::RESP_DECERR, 32'(r));
        chk("miss data", 0, d);
        bus_wr(12'h408, 32'h0);
        chk("miss bresp", cfp_pkg::RESP_DECERR, 32'(r));
        $display("test file map done");
        // bank one selected: the core store now lands at B0h
        mdl_wr('hB0, 0);
        rd_chk('hB0);
        fm['hB0] = 'h55;
        bus_wr(12'h00C, 32'h38);
        repeat (60) @(posedge clk_sys);
        rd_chk('hB0);
        $display("test bank select done");
        // pin edge with interrupts enabled vectors the fetch to four
        bus_wr(12'h02C, 32'h90);
        irqPin <= 1'b1;
        n = 0;
        while (progAddr !== cfp_pkg::IRQ_VECTOR && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq vector", 32'h4, 32'(progAddr));
        irqPin <= 1'b0;
        fm['hB] = 'h12;
        rd_chk('h0B);
        $display("test interrupt vector done");
        end_of_test();
    end
endmodule
